//--- logic/lss_consts.vh
`ifndef LSS_CONSTS_VH
`define LSS_CONSTS_VH
// -------------------------------------------------------------
// command encoding (direction, target) after the start bit
// -------------------------------------------------------------
`define LSS_CMD_DATA_READ 2'h2
`define LSS_CMD_STATUS_READ 2'h3
`define LSS_CMD_DATA_WRITE 2'h0
// -------------------------------------------------------------
// sequence and field layout
// -------------------------------------------------------------
`define LSS_DATA_BITS 4'h8
`define LSS_SEQ_LAST 4'hb
`define LSS_STAT_RXFULL_BIT 0
`define LSS_STAT_TXEMPTY_BIT 1
`define LSS_STAT_RXIRQ_BIT 4
`define LSS_STAT_TXIRQ_BIT 5
`define LSS_STATUS_ACCEPT 1'h0
`define LSS_STATUS_REJECT 1'h1
`define LSS_MISO_RESET 1'h0
`endif

//--- logic/lss_sync.v
`timescale 1ns/100ps
// -------------------------------------------------------------
// two-stage synchroniser for a group of pin inputs
// -------------------------------------------------------------
module lss_sync #(
  parameter WIDTH = 3
) (
  input wire clk,
  input wire srst,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;

  // first stage feeds only the second one
  always @(posedge clk) begin
    if (srst) begin
      stage1 <= {WIDTH{1'h0}};
      syncOut <= {WIDTH{1'h0}};
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // lss_sync

//--- logic/lss_slave.v
`timescale 1ns/100ps
`include "lss_consts.vh"
// Summary of operation
// - after start, write setup bits and eight data bits, one status bit goes out on miso on the same rising edge as the last data bit.
// - the write status bit stays valid until the next rising sclk edge after the last data bit.
// - a data write answers 0 when the byte was stored and 1 when it was not.
// - a rejected byte is dropped and the master must send it again.
// - a status read shifts out the eight-bit status byte then a zero status bit.
// - status bit 4 is the receive-full irq enable, bit 5 the transmit-empty irq enable.
// - command is start 1 then direction and target: 10 read, 11 status, 00 write.
// - each transaction moves one byte msb first within twelve clocks.
// - mosi and miso are sampled and changed on the rising sclk edge; select low is acted on at any clk.
module lss_slave (
  input wire clk,
  input wire srst,
  input wire sclk,
  input wire ss,
  input wire mosi,
  input wire rxBufFull,
  input wire txBufEmpty,
  input wire rx_full_irq_enable,
  input wire tx_empty_irq_enable,
  output reg miso,
  output reg misoEn,
  output reg [7:0] rxData,
  output reg rxWrite,
  output reg [7:0] buffer_status_byte
);
  // -----------------------------------------------------------
  // states
  // -----------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_STAT = 2'h3;

  wire [2:0] pinSync;
  reg sclkLast;
  reg [1:0] state;
  reg [1:0] cmd;
  reg cmdCount;
  reg [3:0] bitCount;
  reg [7:0] shiftIn;
  reg [7:0] shiftOut;
  wire sclkRise;
  wire ssS;
  wire mosiS;
  wire sclkS;
  wire [7:0] statusNow;

  // -----------------------------------------------------------
  // pin synchronisation and edge finding
  // -----------------------------------------------------------
  lss_sync #(
    .WIDTH(3)
  ) pinSyncInst (
    .clk(clk),
    .srst(srst),
    .asyncIn({sclk, ss, mosi}),
    .syncOut(pinSync)
  );
  assign sclkS = pinSync[2];
  assign ssS = pinSync[1];
  assign mosiS = pinSync[0];
  assign sclkRise = sclkS & ~sclkLast;

  // -----------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------
  // command compare, shared by the end of the command and the last data bit
  function cmdIs(input [1:0] seen, input [1:0] code);
    cmdIs = (seen == code);
  endfunction

  // source of one status position; unused positions read zero
  function statusBit(input integer pos, input rxFull, input txEmpty,
    input rxIrq, input txIrq);
    case (pos)
      `LSS_STAT_RXFULL_BIT: statusBit = rxFull;
      `LSS_STAT_TXEMPTY_BIT: statusBit = txEmpty;
      `LSS_STAT_RXIRQ_BIT: statusBit = rxIrq;
      `LSS_STAT_TXIRQ_BIT: statusBit = txIrq;
      default: statusBit = 1'h0;
    endcase
  endfunction

  // -----------------------------------------------------------
  // live status byte
  // -----------------------------------------------------------
  // built bit by bit so a new flag only needs a position constant;
  // the byte is captured when the command completes, so a read shows the flags as they stood then
  genvar sb;
  generate
    for (sb = 0; sb < 8; sb = sb + 1) begin : gStatus
      assign statusNow[sb] = statusBit(sb, rxBufFull, txBufEmpty,
        rx_full_irq_enable, tx_empty_irq_enable);
    end
  endgenerate

  // -----------------------------------------------------------
  // transaction sequencer
  // -----------------------------------------------------------
  // mosi and miso activity is taken on the synchronised rising sclk edge,
  // so a master period well above 4 clk periods is needed
  always @(posedge clk) begin
    if (srst) begin
      sclkLast <= 1'h0;
      state <= ST_IDLE;
      cmd <= 2'h0;
      cmdCount <= 1'h0;
      bitCount <= 4'h0;
      shiftIn <= 8'h00;
      shiftOut <= 8'h00;
      miso <= `LSS_MISO_RESET;
      misoEn <= 1'h0;
      rxData <= 8'h00;
      rxWrite <= 1'h0;
      buffer_status_byte <= 8'h00;
    end else begin
      sclkLast <= sclkS;
      // the buffer push is a single clk pulse
      rxWrite <= 1'h0;
      // registered copy, one clk behind the live flags
      buffer_status_byte <= statusNow;
      if (!ssS) begin
        // select low aborts any partial transaction; a partial byte
        // is never pushed, so the master simply resends the frame
        state <= ST_IDLE;
        misoEn <= 1'h0;
        miso <= `LSS_MISO_RESET;
      end else if (sclkRise) begin
        case (state)
          ST_IDLE: begin
            misoEn <= 1'h0;
            if (mosiS) begin // start bit
              state <= ST_CMD;
              cmdCount <= 1'h0;
            end
          end
          ST_CMD: begin
            // direction then target, shifted in behind the start bit
            cmd <= {cmd[0], mosiS};
            cmdCount <= 1'h1;
            if (cmdCount) begin
              bitCount <= 4'h0;
              state <= ST_DATA;
              // the line is driven from here up to the status bit
              misoEn <= 1'h1;
              if (cmdIs({cmd[0], mosiS}, `LSS_CMD_STATUS_READ)) begin
                // first status bit goes out on this edge, msb first
                miso <= statusNow[7];
                shiftOut <= {statusNow[6:0], 1'h0};
              end else begin
                // data read lives in another block; drive zeros here
                miso <= 1'h0;
                shiftOut <= 8'h00;
              end
            end
          end
          ST_DATA: begin
            shiftIn <= {shiftIn[6:0], mosiS};
            bitCount <= bitCount + 4'h1;
            if (bitCount == `LSS_DATA_BITS - 4'h1) begin
              state <= ST_STAT;
              if (cmdIs(cmd, `LSS_CMD_DATA_WRITE)) begin
                // fill level judged on the last data bit edge only,
                // so space freed during the byte is still used
                if (rxBufFull) begin
                  miso <= `LSS_STATUS_REJECT;
                end else begin
                  miso <= `LSS_STATUS_ACCEPT;
                  rxData <= {shiftIn[6:0], mosiS};
                  rxWrite <= 1'h1;
                end
              end else begin
                // status read trailer is always zero; no buffer touched
                miso <= 1'h0;
              end
            end else begin
              miso <= shiftOut[7];
              shiftOut <= {shiftOut[6:0], 1'h0};
            end
          end
          ST_STAT: begin
            // status bit held only until this edge
            misoEn <= 1'h0;
            miso <= `LSS_MISO_RESET;
            if (mosiS) begin // back-to-back start while still selected
              state <= ST_CMD;
              cmdCount <= 1'h0;
            end else begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // lss_slave

//--- dv/lss_asserts.sv
`timescale 1ns/100ps
// --
// port checks
// --
module lss_asserts (
  input wire clk,
  input wire srst,
  input wire sclk,
  input wire ss,
  input wire mosi,
  input wire rxBufFull,
  input wire txBufEmpty,
  input wire rx_full_irq_enable,
  input wire tx_empty_irq_enable,
  input wire miso,
  input wire misoEn,
  input wire [7:0] rxData,
  input wire rxWrite,
  input wire [7:0] buffer_status_byte
);
  // one domain, reset masks everything
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_status_unused: assert property (buffer_status_byte[7:6] == 2'h0
    && buffer_status_byte[3:2] == 2'h0) else $error("unused bits set");
  a_status_flags: assert property (!$past(srst) |->
    buffer_status_byte[1:0] == {$past(txBufEmpty), $past(rxBufFull)})
    else $error("flag bits wrong");
  a_status_irq: assert property (!$past(srst) |->
    buffer_status_byte[5:4] == {$past(tx_empty_irq_enable),
    $past(rx_full_irq_enable)}) else $error("enable bits wrong");
  a_write_pulse: assert property (rxWrite |=> !rxWrite)
    else $error("long write pulse");
  a_write_accept: assert property (rxWrite |-> misoEn && !miso)
    else $error("write without accept");
  a_data_on_write: assert property ($changed(rxData) |-> rxWrite)
    else $error("byte moved alone");
  a_reject_full: assert property (rxBufFull [*2] |=> !rxWrite)
    else $error("write while full");
  a_select_abort: assert property ($fell(ss) |-> ##[1:5] !misoEn)
    else $error("miso still driven");
endmodule // lss_asserts
bind lss_slave lss_asserts chk (.clk, .srst, .sclk, .ss, .mosi, .rxBufFull,
  .txBufEmpty, .rx_full_irq_enable, .tx_empty_irq_enable, .miso, .misoEn,
  .rxData, .rxWrite, .buffer_status_byte);

//--- dv/lss_master.sv
`timescale 1ns/100ps
// --
// far-side master
// --
module lss_master (
  output logic sclk,
  output logic ss,
  output logic mosi,
  input wire miso
);
  // link clock rests low between frames
  initial {sclk, ss, mosi} = 3'h0;
  // twelve rising edges; mosi moves mid-bit so sync skew cannot bite
  task automatic xfer(input logic [1:0] cmd, input logic [7:0] d,
    output logic [8:0] got);
    logic [10:0] tx;
    tx = {1'h1, cmd, d};
    ss = 1'h1;
    for (int i = 0; i < 12; i++) begin
      mosi = (i < 11) ? tx[10 - i] : 1'h0;
      #80 sclk = 1'h1;
      if (i > 2) got = {got[7:0], miso};
      #80 sclk = 1'h0;
    end
    ss = 1'h0;
    #160;
  endtask
  // a frame dropped after k edges (k below 12); select falls with sclk low
  task automatic cut(input logic [1:0] cmd, input int k);
    logic [10:0] tx;
    tx = {1'h1, cmd, 8'hff};
    ss = 1'h1;
    for (int i = 0; i < k; i++) begin
      mosi = tx[10 - i];
      #80 sclk = 1'h1;
      #80 sclk = 1'h0;
    end
    ss = 1'h0;
    #160;
  endtask
endmodule // lss_master

//--- dv/lss_slave_tb.sv
`timescale 1ns/100ps
// --
// bench
// --
module lss_slave_tb;
  logic clk = 0, srst = 1, rxBufFull = 0, txBufEmpty = 0, rxIe = 0, txIe = 0;
  wire sclk, ss, mosi, miso, misoEn, rxWrite;
  wire [7:0] rxData, stat;
  logic [8:0] got, ex;
  logic [1:0] cmd;
  logic [7:0] d;
  logic f, te, ri, ti, wr;
  int failures = 0, comparisons = 0, writes = 0, n;
  // cmd, byte, {full, empty, rx irq, tx irq}, miso bits then status
  logic [22:0] rows [7] = '{
    {2'h0, 8'ha5, 4'h0, 9'h000}, {2'h0, 8'h3c, 4'h8, 9'h001},
    {2'h0, 8'h3c, 4'h0, 9'h000}, {2'h3, 8'h00, 4'ha, 9'h022},
    {2'h3, 8'h00, 4'h5, 9'h044}, {2'h2, 8'h00, 4'h0, 9'h000},
    {2'h1, 8'h00, 4'h0, 9'h000}};
  always #10 clk = ~clk;
  always @(posedge clk) if (rxWrite === 1'b1) writes <= writes + 1;
  lss_master m (.sclk, .ss, .mosi, .miso);
  lss_slave uut (.clk, .srst, .sclk, .ss, .mosi, .rxBufFull, .txBufEmpty,
    .rx_full_irq_enable(rxIe), .tx_empty_irq_enable(txIe), .miso, .misoEn,
    .rxData, .rxWrite, .buffer_status_byte(stat));
  task check(input string nm, input logic [8:0] seen, input logic [8:0] e);
    comparisons++;
    if (seen !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // frames are fixed length, so only a stall can reach this
  initial begin
    #400000 failures++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    #2 srst = 0;
    foreach (rows[i]) begin
      {cmd, d, f, te, ri, ti, ex} = rows[i];
      @(posedge clk);
      #2 {rxBufFull, txBufEmpty, rxIe, txIe} = {f, te, ri, ti};
      n = writes;
      wr = cmd == 2'h0 && !f;
      m.xfer(cmd, d, got);
      check("miso", got, ex);
      check("writes", 9'(writes - n), {8'h0, wr});
      if (wr) check("rxData", {1'h0, rxData}, {1'h0, d});
      check("status", {1'h0, stat}, {3'h0, ti, ri, 2'h0, te, f});
      check("misoEn", {8'h0, misoEn}, 9'h000);
      $display("row %0d done", i);
    end
    // frames cut mid-byte: the line is released and nothing is pushed
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      #2 rxBufFull = 0;
      n = writes;
      m.cut(k ? 2'h0 : 2'h3, 7);
      check("cutEn", {8'h0, misoEn}, 9'h000);
      check("cutWr", 9'(writes - n), 9'h000);
    end
    // the next full write after a cut is taken normally
    @(posedge clk);
    #2 n = writes;
    m.xfer(2'h0, 8'h5a, got);
    check("cutMiso", got, 9'h000);
    check("cutData", {1'h0, rxData}, 9'h05a);
    check("cutOne", 9'(writes - n), 9'h001);
    $display("cut frame test done");
    // a second reset in mid-run clears outputs and the held byte
    @(posedge clk);
    #2 srst = 1;
    repeat (5) @(posedge clk);
    #2 check("reset", {misoEn, miso, rxWrite, stat[5:0]}, 9'h000);
    check("rxData", {1'h0, rxData}, 9'h000);
    srst = 0;
    $display("reset test done");
    summarize();
  end
endmodule // lss_slave_tb
